// ==== src/i2smap_core.sv ====
// I2S pin-to-FIFO routing, channel status bytes and register port.
//
// The strobed register port was chosen for this implementation.
`default_nettype none
// Notes on behaviour
// - One SD input may feed several FIFOs
// - FIFO mapped to disabled SD takes nothing
// - Map fields: enable, pin, downsample, swap, FIFO
// - Map readback returns last written value
// - Byte 4 low nibble is word length
// - Sampling frequency codes per table
// - Byte 3: accuracy high, frequency low
// - Byte 2: channel high, source low
// - Byte 4: original rate high, length low
// - Status bytes usable only when select is 10
module i2smap_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic linkClock,
  input wire logic linkWs,
  input wire logic [3:0] linkSd,
  output logic [3:0] fifoSample,
  output logic [3:0] fifoLeft,
  output logic [3:0] fifoWrite,
  output logic [3:0] fifoEnabled,
  output logic downSample,
  output logic [7:0] statusByte2,
  output logic [7:0] statusByte3,
  output logic [7:0] statusByte4,
  output logic wordLenValid,
  output logic rateValid,
  output logic i2sSelected
);
  function automatic logic isWordLen(input logic [3:0] code);
    unique case (code)
      i2smap_pkg::WORD_LEN_24,
      i2smap_pkg::WORD_LEN_23,
      i2smap_pkg::WORD_LEN_22,
      i2smap_pkg::WORD_LEN_21,
      i2smap_pkg::WORD_LEN_20,
      i2smap_pkg::WORD_LEN_19,
      i2smap_pkg::WORD_LEN_18,
      i2smap_pkg::WORD_LEN_17,
      i2smap_pkg::WORD_LEN_16: isWordLen = 1'b1;
      default: isWordLen = 1'b0;
    endcase
  endfunction

  function automatic logic isRate(input logic [3:0] code);
    unique case (code)
      i2smap_pkg::FS_44K1,
      i2smap_pkg::FS_88K2,
      i2smap_pkg::FS_176K4,
      i2smap_pkg::FS_48K,
      i2smap_pkg::FS_96K,
      i2smap_pkg::FS_192K,
      i2smap_pkg::FS_32K,
      i2smap_pkg::FS_HIGH_BITRATE,
      i2smap_pkg::FS_NOT_INDICATED: isRate = 1'b1;
      default: isRate = 1'b0;
    endcase
  endfunction

  logic [7:0] mapLast_ff;
  logic [7:0] csByte0_ff;
  logic [7:0] csByte1_ff;
  logic [7:0] csByte2_ff;
  logic [7:0] csByte3_ff;
  logic [7:0] csByte4_ff;
  logic [7:0] audioSel_ff;
  logic [7:0] nxt_regRdData;
  logic [3:0] routeEn_ff;
  logic [3:0] routeSwap_ff;
  logic [1:0] routePin_ff [4];
  logic downSample_ff;
  logic csWriteOk;

  assign csWriteOk = (audioSel_ff[i2smap_pkg::SEL_HI:i2smap_pkg::SEL_LO] == i2smap_pkg::SEL_I2S);
  assign i2sSelected = csWriteOk;

  // Only the last write is kept for readback; the routing table lives separately
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mapLast_ff <= i2smap_pkg::RST_PIN_FIFO_MAP;
    end else if (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP) begin
      mapLast_ff <= regWrData;
    end
  end

  // Each map write updates only the FIFO it names, so several FIFOs may share one pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      routeEn_ff <= 4'h0;
      routeSwap_ff <= 4'h0;
      for (int i = 0; i < i2smap_pkg::NUM_FIFO; i++) begin
        routePin_ff[i] <= 2'h0;
      end
    end else if (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP) begin
      routeEn_ff[regWrData[i2smap_pkg::MAP_FIFO_HI:i2smap_pkg::MAP_FIFO_LO]] <=
        regWrData[i2smap_pkg::MAP_ENABLE_BIT];
      routeSwap_ff[regWrData[i2smap_pkg::MAP_FIFO_HI:i2smap_pkg::MAP_FIFO_LO]] <=
        regWrData[i2smap_pkg::MAP_SWAP_BIT];
      routePin_ff[regWrData[i2smap_pkg::MAP_FIFO_HI:i2smap_pkg::MAP_FIFO_LO]] <=
        regWrData[i2smap_pkg::MAP_PIN_HI:i2smap_pkg::MAP_PIN_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      downSample_ff <= 1'b0;
    end else if (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP) begin
      downSample_ff <= regWrData[i2smap_pkg::MAP_DOWNSAMPLE_BIT];
    end
  end
  assign downSample = downSample_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      audioSel_ff <= i2smap_pkg::RST_AUDIO_SELECT;
    end else if (regWrite && regAddr == i2smap_pkg::ADDR_AUDIO_SELECT) begin
      audioSel_ff <= regWrData;
    end
  end

  // Status bytes only take writes while I2S is the selected input
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      csByte0_ff <= i2smap_pkg::RST_CS_BYTE_ZERO;
      csByte1_ff <= i2smap_pkg::RST_CS_CATEGORY;
      csByte2_ff <= i2smap_pkg::RST_CS_SRC_CHAN;
      csByte3_ff <= i2smap_pkg::RST_CS_ACC_RATE;
      csByte4_ff <= i2smap_pkg::RST_CS_ORIG_LEN;
    end else if (regWrite && csWriteOk) begin
      if (regAddr == i2smap_pkg::ADDR_CS_BYTE_ZERO) csByte0_ff <= regWrData;
      if (regAddr == i2smap_pkg::ADDR_CS_CATEGORY) csByte1_ff <= regWrData;
      if (regAddr == i2smap_pkg::ADDR_CS_SRC_CHAN) csByte2_ff <= regWrData;
      if (regAddr == i2smap_pkg::ADDR_CS_ACC_RATE) csByte3_ff <= regWrData;
      if (regAddr == i2smap_pkg::ADDR_CS_ORIG_LEN) csByte4_ff <= regWrData;
    end
  end

  assign statusByte2 = csByte2_ff;
  assign statusByte3 = csByte3_ff;
  assign statusByte4 = csByte4_ff;
  assign wordLenValid = isWordLen(csByte4_ff[3:0]);
  assign rateValid = isRate(csByte3_ff[3:0]);

  always_comb begin
    nxt_regRdData = 8'h00;
    unique case (regAddr)
      i2smap_pkg::ADDR_PIN_FIFO_MAP: nxt_regRdData = mapLast_ff;
      i2smap_pkg::ADDR_CS_BYTE_ZERO: nxt_regRdData = csWriteOk ? csByte0_ff : 8'h00;
      i2smap_pkg::ADDR_CS_CATEGORY: nxt_regRdData = csWriteOk ? csByte1_ff : 8'h00;
      i2smap_pkg::ADDR_CS_SRC_CHAN: nxt_regRdData = csWriteOk ? csByte2_ff : 8'h00;
      i2smap_pkg::ADDR_CS_ACC_RATE: nxt_regRdData = csWriteOk ? csByte3_ff : 8'h00;
      i2smap_pkg::ADDR_CS_ORIG_LEN: nxt_regRdData = csWriteOk ? csByte4_ff : 8'h00;
      i2smap_pkg::ADDR_AUDIO_SELECT: nxt_regRdData = audioSel_ff;
      default: nxt_regRdData = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRead ? nxt_regRdData : 8'h00;
    end
  end

  // The routing table crosses as one bundle under a toggle handshake; only the
  // toggle is synchronised, the bundle is held still until the far side takes it
  logic [3:0] linkEn_ff;
  logic [3:0] linkSwap_ff;
  logic [7:0] linkPin_ff;
  logic linkRstMeta_ff;
  logic linkRst_n;
  logic [7:0] pinFlat;
  logic [15:0] cfgLive;
  logic [15:0] cfgHold_ff;
  logic cfgReq_ff;
  logic ackMeta_ff;
  logic ackSync_ff;
  logic reqMeta_ff;
  logic reqSync_ff;
  logic cfgAck_ff;

  assign pinFlat = {routePin_ff[3], routePin_ff[2], routePin_ff[1], routePin_ff[0]};
  assign cfgLive = {pinFlat, routeSwap_ff, routeEn_ff};

  // A new snapshot is taken only when no handoff is in flight
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgHold_ff <= 16'h0000;
      cfgReq_ff <= 1'b0;
    end else if (cfgReq_ff == ackSync_ff && cfgLive != cfgHold_ff) begin
      cfgHold_ff <= cfgLive;
      cfgReq_ff <= ~cfgReq_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ackMeta_ff <= 1'b0;
      ackSync_ff <= 1'b0;
    end else begin
      ackMeta_ff <= cfgAck_ff;
      ackSync_ff <= ackMeta_ff;
    end
  end

  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      linkRstMeta_ff <= 1'b0;
      linkRst_n <= 1'b0;
    end else begin
      linkRstMeta_ff <= 1'b1;
      linkRst_n <= linkRstMeta_ff;
    end
  end

  always_ff @(posedge linkClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      reqMeta_ff <= 1'b0;
      reqSync_ff <= 1'b0;
    end else begin
      reqMeta_ff <= cfgReq_ff;
      reqSync_ff <= reqMeta_ff;
    end
  end

  always_ff @(posedge linkClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      linkEn_ff <= 4'h0;
      linkSwap_ff <= 4'h0;
      linkPin_ff <= 8'h00;
      cfgAck_ff <= 1'b0;
    end else if (reqSync_ff != cfgAck_ff) begin
      linkEn_ff <= cfgHold_ff[3:0];
      linkSwap_ff <= cfgHold_ff[7:4];
      linkPin_ff <= cfgHold_ff[15:8];
      cfgAck_ff <= reqSync_ff;
    end
  end

  logic [3:0] sdMeta_ff;
  logic [3:0] sd_ff;
  logic wsMeta_ff;
  logic ws_ff;

  always_ff @(posedge linkClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      sdMeta_ff <= 4'h0;
      sd_ff <= 4'h0;
      wsMeta_ff <= 1'b0;
      ws_ff <= 1'b0;
    end else begin
      sdMeta_ff <= linkSd;
      sd_ff <= sdMeta_ff;
      wsMeta_ff <= linkWs;
      ws_ff <= wsMeta_ff;
    end
  end

  wire logic [3:0] nxtSample;
  wire logic [3:0] nxtLeft;
  genvar g;
  generate
    for (g = 0; g < i2smap_pkg::NUM_FIFO; g++) begin : gFifo
      assign nxtSample[g] = sd_ff[linkPin_ff[2*g +: 2]];
      assign nxtLeft[g] = ws_ff ^ linkSwap_ff[g];
    end
  endgenerate

  always_ff @(posedge linkClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      fifoSample <= 4'h0;
      fifoLeft <= 4'h0;
      fifoWrite <= 4'h0;
    end else begin
      fifoSample <= nxtSample;
      fifoLeft <= nxtLeft;
      fifoWrite <= linkEn_ff;
    end
  end
  assign fifoEnabled = linkEn_ff;

  disabled_fifo_a: assert property (@(posedge linkClock) disable iff (!linkRst_n)
    !linkEn_ff[0] |=> !fifoWrite[0]) else $error("Write into disabled FIFO");

  sd_route_a: assert property (@(posedge linkClock) disable iff (!linkRst_n)
    fifoEnabled[1] |=> fifoSample[1] == $past(sd_ff[linkPin_ff[3:2]])) else $error("Sample from wrong pin");

  side_flag_a: assert property (@(posedge linkClock) disable iff (!linkRst_n)
    fifoEnabled[3] |=> fifoLeft[3] == $past(ws_ff ^ linkSwap_ff[3])) else $error("Channel side wrong");

  cfg_handoff_a: assert property (@(posedge linkClock) disable iff (!linkRst_n)
    reqSync_ff != cfgAck_ff |=> linkEn_ff == $past(cfgHold_ff[3:0]) && linkPin_ff == $past(cfgHold_ff[15:8]))
    else $error("Routing handoff lost");

  cfg_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfgReq_ff != ackSync_ff |=> $stable(cfgHold_ff)) else $error("Snapshot moved in flight");

  map_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP) ##1 (regRead && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP)
    |=> regRdData == $past(regWrData, 2)) else $error("Map readback wrong");

  rd_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    !regRead |=> regRdData == 8'h00) else $error("Read data outside its cycle");

  route_update_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP && regWrData[1:0] == 2'h2)
    |=> routeEn_ff[2] == $past(regWrData[7]) && routePin_ff[2] == $past(regWrData[5:4])) else
    $error("Routing entry not updated");

  swap_update_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP && regWrData[1:0] == 2'h3)
    |=> routeSwap_ff[3] == $past(regWrData[2])) else $error("Swap flag not updated");

  down_sample_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP)
    |=> downSample == $past(regWrData[3])) else $error("Down-sample bit not updated");

  route_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == i2smap_pkg::ADDR_PIN_FIFO_MAP && regWrData[1:0] != 2'h1)
    |=> $stable(routePin_ff[1]) && $stable(routeEn_ff[1])) else $error("Other FIFO entry changed");

  cs_locked_a: assert property (@(posedge clock) disable iff (!rst_n)
    !csWriteOk |=> $stable(csByte4_ff) && $stable(csByte3_ff)) else $error("Status changed unselected");

  locked_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regRead && !csWriteOk && regAddr == i2smap_pkg::ADDR_CS_ORIG_LEN)
    |=> regRdData == 8'h00) else $error("Locked status byte readable");

  sel_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == i2smap_pkg::ADDR_AUDIO_SELECT)
    |=> audioSel_ff == $past(regWrData)) else $error("Input select not stored");

  sel_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == i2smap_pkg::ADDR_AUDIO_SELECT)
    |=> regRdData == $past(audioSel_ff)) else $error("Input select readback wrong");

  len_nibble_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && csWriteOk && regAddr == i2smap_pkg::ADDR_CS_ORIG_LEN)
    |=> statusByte4[3:0] == $past(regWrData[3:0])) else $error("Word length not stored");

  len_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    statusByte4[3:0] == i2smap_pkg::WORD_LEN_24 |-> wordLenValid) else $error("24-bit code rejected");

  len_illegal_a: assert property (@(posedge clock) disable iff (!rst_n)
    statusByte4[3:0] == 4'hf |-> !wordLenValid) else $error("Illegal length accepted");

  rate_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    statusByte3[3:0] == 4'hf |-> !rateValid) else $error("Illegal rate accepted");

  rate_legal_a: assert property (@(posedge clock) disable iff (!rst_n)
    statusByte3[3:0] == i2smap_pkg::FS_HIGH_BITRATE |-> rateValid) else $error("High bitrate code rejected");

  acc_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && csWriteOk && regAddr == i2smap_pkg::ADDR_CS_ACC_RATE)
    |=> statusByte3 == $past(regWrData)) else $error("Accuracy byte not stored");

  src_chan_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && csWriteOk && regAddr == i2smap_pkg::ADDR_CS_SRC_CHAN)
    |=> statusByte2[7:4] == $past(regWrData[7:4]) && statusByte2[3:0] == $past(regWrData[3:0])) else
    $error("Channel byte not stored");

  orig_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (regWrite && csWriteOk && regAddr == i2smap_pkg::ADDR_CS_ORIG_LEN)
    |=> statusByte4[7:4] == $past(regWrData[7:4])) else $error("Original rate not stored");
endmodule
`default_nettype wire

// ==== src/i2smap_pkg.sv ====
// Package with register map, field positions, reset values and codes for the I2S input mapping block.
`default_nettype none
package i2smap_pkg;
  localparam logic [7:0] ADDR_PIN_FIFO_MAP = 8'h1f;
  localparam logic [7:0] ADDR_CS_BYTE_ZERO = 8'h21;
  localparam logic [7:0] ADDR_CS_CATEGORY = 8'h22;
  localparam logic [7:0] ADDR_CS_SRC_CHAN = 8'h23;
  localparam logic [7:0] ADDR_CS_ACC_RATE = 8'h24;
  localparam logic [7:0] ADDR_CS_ORIG_LEN = 8'h25;
  localparam logic [7:0] ADDR_AUDIO_SELECT = 8'h26;
  localparam logic [7:0] RST_PIN_FIFO_MAP = 8'h00;
  localparam logic [7:0] RST_CS_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RST_CS_CATEGORY = 8'h00;
  localparam logic [7:0] RST_CS_SRC_CHAN = 8'h00;
  localparam logic [7:0] RST_CS_ACC_RATE = 8'h0f;
  localparam logic [7:0] RST_CS_ORIG_LEN = 8'h0b;
  localparam logic [7:0] RST_AUDIO_SELECT = 8'h00;
  localparam int MAP_ENABLE_BIT = 7;
  localparam int MAP_PIN_HI = 5;
  localparam int MAP_PIN_LO = 4;
  localparam int MAP_DOWNSAMPLE_BIT = 3;
  localparam int MAP_SWAP_BIT = 2;
  localparam int MAP_FIFO_HI = 1;
  localparam int MAP_FIFO_LO = 0;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam logic [1:0] SEL_I2S = 2'h2;
  localparam logic [3:0] WORD_LEN_24 = 4'hb;
  localparam logic [3:0] WORD_LEN_23 = 4'h9;
  localparam logic [3:0] WORD_LEN_22 = 4'h5;
  localparam logic [3:0] WORD_LEN_21 = 4'hd;
  localparam logic [3:0] WORD_LEN_20 = 4'ha;
  localparam logic [3:0] WORD_LEN_19 = 4'h8;
  localparam logic [3:0] WORD_LEN_18 = 4'h4;
  localparam logic [3:0] WORD_LEN_17 = 4'hc;
  localparam logic [3:0] WORD_LEN_16 = 4'h2;
  localparam logic [3:0] FS_44K1 = 4'h0;
  localparam logic [3:0] FS_88K2 = 4'h8;
  localparam logic [3:0] FS_176K4 = 4'hc;
  localparam logic [3:0] FS_48K = 4'h2;
  localparam logic [3:0] FS_96K = 4'ha;
  localparam logic [3:0] FS_192K = 4'he;
  localparam logic [3:0] FS_32K = 4'h3;
  localparam logic [3:0] FS_HIGH_BITRATE = 4'h9;
  localparam logic [3:0] FS_NOT_INDICATED = 4'h1;
  localparam int NUM_FIFO = 4;
  localparam int NUM_SD = 4;
endpackage
`default_nettype wire

// ==== verification/i2s_input_mapping_and_channel_status_test.sv ====
// Self-checking bench for the I2S mapping and channel status block.
`default_nettype none
module i2s_input_mapping_and_channel_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, rst_n = 1'b0, linkClock = 1'b0, regWrite = 1'b0, regRead = 1'b0, wsLevel = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, sb2, sb3, sb4, d, mLast;
  logic [3:0] sdLevel = 4'h0, linkSd, fifoSample, fifoLeft, fifoWrite, fifoEnabled;
  logic linkWs, downSample, wordLenValid, rateValid, i2sSelected;
  logic [3:0] wl[10] = '{4'hb, 4'h9, 4'h5, 4'hd, 4'ha, 4'h8, 4'h4, 4'hc, 4'h2, 4'hf};
  logic [3:0] fs[10] = '{4'h0, 4'h8, 4'hc, 4'h2, 4'ha, 4'he, 4'h3, 4'h9, 4'h1, 4'hf};
  int num_errors = 0, num_checks = 0, mDown = 0;
  int mPin[4], mEn[4], mSwap[4];
  always #25 clock = ~clock;
  initial begin
    #1.7;
    forever #3 linkClock = ~linkClock;
  end
  i2smap_source u_i2smap_source (.linkClock, .rst_n, .wsLevel, .sdLevel, .linkWs, .linkSd);
  i2smap_core u_i2smap_core (.clock, .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .linkClock, .linkWs, .linkSd, .fifoSample, .fifoLeft, .fifoWrite, .fifoEnabled, .downSample,
    .statusByte2(sb2), .statusByte3(sb3), .statusByte4(sb4), .wordLenValid, .rateValid, .i2sSelected);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk(regRdData, exp);
  endtask
  task automatic mapWr(input int f, input int p, input int e, input int s, input int dn);
    mPin[f] = p;
    mEn[f] = e;
    mSwap[f] = s;
    mDown = dn;
    mLast = {e[0], 1'b0, p[1:0], dn[0], s[0], f[1:0]};
    wr(8'h1f, mLast);
  endtask
  // Link outputs are judged only after the config and pins had time to cross
  task automatic linkChk(input logic [3:0] sd, input logic ws);
    logic [3:0] en, smp, lft;
    @(posedge clock);
    sdLevel <= sd;
    wsLevel <= ws;
    repeat (10) @(posedge clock);
    for (int f = 0; f < 4; f++) begin
      en[f] = (mEn[f] != 0);
      smp[f] = sd[mPin[f]];
      lft[f] = ws ^ mSwap[f][0];
    end
    chk({4'h0, fifoEnabled}, {4'h0, en});
    chk({4'h0, fifoWrite}, {4'h0, en});
    chk({4'h0, fifoSample & en}, {4'h0, smp & en});
    chk({4'h0, fifoLeft & en}, {4'h0, lft & en});
    chk({7'h0, downSample}, mDown[7:0]);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    $display("[FAIL] %0t: run limit reached", $time);
    results();
  end
  initial begin
    void'($urandom(32'h853915d3));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    chk(sb2, 8'h00);
    chk(sb3, 8'h0f);
    chk(sb4, 8'h0b);
    rdChk(8'h1f, 8'h00);
    wr(8'h25, 8'h12);
    rdChk(8'h25, 8'h00);
    chk(sb4, 8'h0b);
    chk({7'h0, i2sSelected}, 8'h00);
    $display("Test locked status done");
    wr(8'h26, 8'h80);
    rdChk(8'h26, 8'h80);
    chk({7'h0, i2sSelected}, 8'h01);
    for (int a = 8'h21; a <= 8'h25; a++) begin
      d = 8'($urandom);
      wr(a[7:0], d);
      rdChk(a[7:0], d);
      if (a == 8'h23) chk(sb2, d);
      if (a == 8'h24) chk(sb3, d);
      if (a == 8'h25) chk(sb4, d);
    end
    rdChk(8'h40, 8'h00);
    for (int i = 0; i < 10; i++) begin
      wr(8'h25, {4'h7, wl[i]});
      wr(8'h24, {4'h5, fs[i]});
      @(negedge clock);
      chk(sb4, {4'h7, wl[i]});
      chk(sb3, {4'h5, fs[i]});
      chk({7'h0, wordLenValid}, {7'h0, i < 9});
      chk({7'h0, rateValid}, {7'h0, i < 9});
    end
    $display("Test status codes done");
    mapWr(0, 1, 1, 0, 0);
    mapWr(1, 1, 1, 0, 0);
    mapWr(2, 1, 1, 0, 0);
    mapWr(3, 1, 1, 1, 1);
    rdChk(8'h1f, mLast);
    linkChk(4'h2, 1'b1);
    linkChk(4'hd, 1'b0);
    mapWr(1, 2, 1, 1, 0);
    mapWr(2, 0, 0, 0, 0);
    mapWr(3, 0, 0, 0, 0);
    rdChk(8'h1f, mLast);
    linkChk(4'h4, 1'b1);
    linkChk(4'($urandom), 1'b0);
    $display("Test mapping done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk(sb3, 8'h0f);
    chk({4'h0, fifoWrite}, 8'h00);
    rst_n <= 1'b1;
    rdChk(8'h24, 8'h00);
    $display("Test second reset done");
    results();
  end
endmodule
`default_nettype wire

// ==== verification/i2smap_source.sv ====
// I2S source model driving word select and the four serial data lines.
`default_nettype none
module i2smap_source (
  input wire logic linkClock,
  input wire logic rst_n,
  input wire logic wsLevel,
  input wire logic [3:0] sdLevel,
  output logic linkWs,
  output logic [3:0] linkSd
);
  timeunit 1ns;
  timeprecision 100ps;
  // Change on the falling edge so the receiver always samples settled lines
  always_ff @(negedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      linkWs <= 1'b0;
      linkSd <= 4'h0;
    end else begin
      linkWs <= wsLevel;
      linkSd <= sdLevel;
    end
  end
endmodule
`default_nettype wire
